// ===== rtl/sws_sequencer.v
// suspend/wake sequencer with APB register access
`timescale 1ns/1ps
`include "sws_defines.vh"
module sws_sequencer (
  input  wire        CLK,
  input  wire        RESET_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        SLEEP_REQ,
  input  wire [7:0]  WAKE_PINS,
  input  wire        CONFIG_DONE,
  input  wire        ENTRY_ACKNOWLEDGE,
  output reg         ENTRY_REQUEST_OUT,
  input  wire [7:0]  HOLD_LAST_LEVEL,
  output reg  [7:0]  HOLD_CAPTURED,
  output reg         WRITE_ENABLE,
  output reg         OUTPUT_HOLD,
  output reg         INPUT_BLOCK,
  output reg         GLOBAL_SET_RESET,
  input  wire        AWAKE_IN,
  output reg         AWAKE_OUT,
  output reg         AWAKE_OE,
  output reg         AWAKE_IS_STATUS
);

  localparam [3:0] ST_RUN     = 4'h0;
  localparam [3:0] ST_HSK     = 4'h1;
  localparam [3:0] ST_GWE     = 4'h2;
  localparam [3:0] ST_AWK_LO  = 4'h3;
  localparam [3:0] ST_GTS     = 4'h4;
  localparam [3:0] ST_DIS     = 4'h5;
  localparam [3:0] ST_SUSP    = 4'h6;
  localparam [3:0] ST_EN      = 4'h7;
  localparam [3:0] ST_AWK_HI  = 4'h8;
  localparam [3:0] ST_AWK_WT  = 4'h9;
  localparam [3:0] ST_REL     = 4'ha;
  localparam [3:0] ST_CONFIG  = 4'hb;

  localparam [7:0] CYC_GWE    = `SWS_CYC_GWE;
  localparam [7:0] CYC_AWAKE  = `SWS_CYC_AWAKE;
  localparam [7:0] CYC_GTS    = `SWS_CYC_GTS;
  localparam [7:0] CYC_DIS    = `SWS_CYC_DIS;
  localparam [7:0] CYC_EN     = `SWS_CYC_EN;
  localparam [7:0] CYC_AWK_HI = `SWS_CYC_AWK_HI;

  reg  [31:0] ctrl_ff;
  reg  [7:0]  out_cnt_ff;
  reg  [7:0]  wr_cnt_ff;
  reg  [31:0] prdata_ff;
  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg  [7:0]  tmr_ff;
  reg  [7:0]  nxt_tmr;
  reg  [7:0]  rel_ff;
  reg  [7:0]  nxt_rel;
  reg  [7:0]  hold_val_ff;
  reg  [1:0]  sleep_sync_ff;
  reg  [1:0]  awake_sync_ff;
  wire [7:0]  wake_sync;
  wire [7:0]  wake_hit;
  reg  [2:0]  filt_cnt_ff;
  reg         sleep_filt_ff;
  genvar      gi;

  wire [1:0] en_mode  = ctrl_ff[`SWS_CTRL_EN_LSB+1:`SWS_CTRL_EN_LSB];
  wire       enabled  = (en_mode == `SWS_EN_FILTER) || (en_mode == `SWS_EN_NOFILTER);
  wire       hsk_en   = ctrl_ff[`SWS_CTRL_HSK];
  wire       multi_en = ctrl_ff[`SWS_CTRL_MULTI];
  wire       drive_en = ctrl_ff[`SWS_CTRL_DRIVE];
  wire       gsr_en   = ctrl_ff[`SWS_CTRL_GSR];
  wire [7:0] wake_msk = ctrl_ff[`SWS_CTRL_MASK_LSB+7:`SWS_CTRL_MASK_LSB];

  wire wr_acc = PSEL && PENABLE && PWRITE;
  wire rd_set = PSEL && !PENABLE && !PWRITE;
  wire sleep_raw = sleep_sync_ff[1];
  // filter only when selected; enabled_no_filter path uses the synchronised level directly
  wire sleep_lvl = (en_mode == `SWS_EN_FILTER) ? sleep_filt_ff : sleep_raw;
  wire wake_any = multi_en && (|wake_hit);
  wire exit_cond = !sleep_lvl && (!multi_en || wake_any);
  wire awake_seen = awake_sync_ff[1];

  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;
  assign PRDATA  = prdata_ff;

  // register writes; reads are latched at setup so PRDATA is a flop
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_ff    <= `SWS_CTRL_RESET;
      out_cnt_ff <= `SWS_OUT_CNT_RESET;
      wr_cnt_ff  <= `SWS_WR_CNT_RESET;
      prdata_ff  <= 32'h00000000;
    end else begin
      if (wr_acc && PADDR == `SWS_ADDR_CTRL) begin
        ctrl_ff <= PWDATA & 32'h0000ff3f;
      end
      if (wr_acc && PADDR == `SWS_ADDR_TIMING) begin
        out_cnt_ff <= PWDATA[7:0];
        wr_cnt_ff  <= PWDATA[15:8];
      end
      if (rd_set) begin
        case (PADDR)
          `SWS_ADDR_CTRL:    prdata_ff <= ctrl_ff;
          `SWS_ADDR_TIMING:  prdata_ff <= {16'h0000, wr_cnt_ff, out_cnt_ff};
          `SWS_ADDR_STATUS:  prdata_ff <= {16'h0000, wake_sync, 1'b0, awake_seen,
                                           WRITE_ENABLE, OUTPUT_HOLD, state_ff};
          `SWS_ADDR_CAPTURE: prdata_ff <= {24'h000000, hold_val_ff};
          default:           prdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // two-stage synchronisers; only the second stage is consumed
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sleep_sync_ff <= 2'h0;
      awake_sync_ff <= 2'h0;
    end else begin
      sleep_sync_ff <= {sleep_sync_ff[0], SLEEP_REQ};
      awake_sync_ff <= {awake_sync_ff[0], AWAKE_IN};
    end
  end

  // per-pin wake path: two-flop synchroniser, then a delayed copy for edge detect
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_wake
      reg meta_ff;
      reg sync_ff;
      reg prev_ff;
      always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          prev_ff <= 1'b0;
        end else begin
          meta_ff <= WAKE_PINS[gi];
          sync_ff <= meta_ff;
          prev_ff <= sync_ff;
        end
      end
      assign wake_sync[gi] = sync_ff;
      // a level already high counts, so a pin high when sleep falls exits at once
      assign wake_hit[gi]  = wake_msk[gi] & (sync_ff | (sync_ff & ~prev_ff));
    end
  endgenerate

  // glitch filter: level must hold for SWS_FILT_LEN cycles to be accepted
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      filt_cnt_ff   <= 3'h0;
      sleep_filt_ff <= 1'b0;
    end else if (sleep_raw == sleep_filt_ff) begin
      filt_cnt_ff <= 3'h0;
    end else if (filt_cnt_ff == `SWS_FILT_LEN - 3'h1) begin
      filt_cnt_ff   <= 3'h0;
      sleep_filt_ff <= sleep_raw;
    end else begin
      filt_cnt_ff <= filt_cnt_ff + 3'h1;
    end
  end

  always @* begin
    nxt_state = state_ff;
    nxt_tmr   = (tmr_ff == 8'h00) ? 8'h00 : tmr_ff - 8'h01;
    nxt_rel   = rel_ff;
    case (state_ff)
      ST_CONFIG: begin
        if (CONFIG_DONE) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (enabled && sleep_lvl) begin
          nxt_state = hsk_en ? ST_HSK : ST_GWE;
          nxt_tmr   = CYC_GWE;
        end
      end
      ST_HSK: begin
        if (!sleep_lvl) begin
          nxt_state = ST_RUN;
        end else if (ENTRY_ACKNOWLEDGE) begin
          nxt_state = ST_GWE;
          nxt_tmr   = CYC_GWE;
        end
      end
      ST_GWE: begin
        if (tmr_ff == 8'h01) begin
          nxt_state = ST_AWK_LO;
          nxt_tmr   = CYC_AWAKE - CYC_GWE;
        end
      end
      ST_AWK_LO: begin
        if (tmr_ff == 8'h01) begin
          nxt_state = ST_GTS;
          nxt_tmr   = CYC_GTS - CYC_AWAKE;
        end
      end
      ST_GTS: begin
        if (tmr_ff == 8'h01) begin
          nxt_state = ST_DIS;
          nxt_tmr   = CYC_DIS - CYC_GTS;
        end
      end
      ST_DIS: begin
        if (tmr_ff == 8'h01) begin
          nxt_state = ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (exit_cond) begin
          nxt_state = ST_EN;
          nxt_tmr   = CYC_EN;
        end
      end
      ST_EN: begin
        if (tmr_ff == 8'h01) begin
          nxt_state = ST_AWK_HI;
          nxt_tmr   = CYC_AWK_HI;
        end
      end
      ST_AWK_HI: begin
        if (tmr_ff == 8'h01) begin
          nxt_state = ST_AWK_WT;
        end
      end
      ST_AWK_WT: begin
        if (awake_seen) begin
          nxt_state = ST_REL;
          nxt_rel   = 8'h00;
        end
      end
      ST_REL: begin
        nxt_rel = rel_ff + 8'h01;
        // the write count is honoured even if below the output count
        if (rel_ff + 8'h01 >= out_cnt_ff && rel_ff + 8'h01 >= wr_cnt_ff) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  // phase edges, decoded once so each output block stays small
  wire go_entry  = (state_ff == ST_RUN || state_ff == ST_HSK) && (nxt_state == ST_GWE);
  wire go_we_off = (state_ff == ST_GWE) && (nxt_state == ST_AWK_LO);
  wire go_awk_lo = (state_ff == ST_AWK_LO) && (nxt_state == ST_GTS);
  wire go_hold   = (state_ff == ST_GTS) && (nxt_state == ST_DIS);
  wire go_block  = (state_ff == ST_DIS) && (nxt_state == ST_SUSP);
  wire go_unblk  = (state_ff == ST_EN) && (nxt_state == ST_AWK_HI);
  wire go_awk_hi = (state_ff == ST_AWK_HI) && (nxt_state == ST_AWK_WT);
  wire out_due   = (state_ff == ST_REL) && (rel_ff + 8'h01 >= out_cnt_ff);
  wire wr_due    = (state_ff == ST_REL) && (rel_ff + 8'h01 >= wr_cnt_ff);

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_CONFIG;
      tmr_ff   <= 8'h00;
      rel_ff   <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      tmr_ff   <= nxt_tmr;
      rel_ff   <= nxt_rel;
    end
  end

  // levels are latched at the entry decision but shown only at the output switchover
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_val_ff   <= 8'h00;
      HOLD_CAPTURED <= 8'h00;
    end else begin
      if (go_entry) begin
        hold_val_ff <= HOLD_LAST_LEVEL;
      end
      if (go_hold) begin
        HOLD_CAPTURED <= hold_val_ff;
      end
    end
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WRITE_ENABLE <= 1'b1;
      OUTPUT_HOLD  <= 1'b0;
      INPUT_BLOCK  <= 1'b0;
    end else begin
      if (go_we_off) begin
        WRITE_ENABLE <= 1'b0;
      end else if (wr_due) begin
        WRITE_ENABLE <= 1'b1;
      end
      if (go_hold) begin
        OUTPUT_HOLD <= 1'b1;
      end else if (out_due) begin
        OUTPUT_HOLD <= 1'b0;
      end
      if (go_block) begin
        INPUT_BLOCK <= 1'b1;
      end else if (go_unblk) begin
        INPUT_BLOCK <= 1'b0;
      end
    end
  end

  // the set/reset pulse spans the awake wait, so a slow pull-up cannot shorten it
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      GLOBAL_SET_RESET  <= 1'b0;
      ENTRY_REQUEST_OUT <= 1'b0;
      AWAKE_IS_STATUS   <= 1'b0;
    end else begin
      AWAKE_IS_STATUS   <= enabled;
      ENTRY_REQUEST_OUT <= (nxt_state == ST_HSK);
      if (go_unblk) begin
        GLOBAL_SET_RESET <= gsr_en;
      end else if (state_ff == ST_REL) begin
        GLOBAL_SET_RESET <= 1'b0;
      end
    end
  end

  // the pin is user I/O while the feature is off, so it is only driven when enabled
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AWAKE_OUT <= 1'b0;
      AWAKE_OE  <= 1'b0;
    end else if (go_awk_lo) begin
      AWAKE_OUT <= 1'b0;
      AWAKE_OE  <= 1'b1;
    end else if (go_awk_hi) begin
      AWAKE_OUT <= drive_en;
      AWAKE_OE  <= drive_en;
    end else if (state_ff == ST_RUN) begin
      AWAKE_OUT <= enabled;
      AWAKE_OE  <= enabled;
    end
  end

endmodule // sws_sequencer

// ===== rtl/sws_defines.vh
// constants for the suspend/wake sequencer
`ifndef SWS_DEFINES_VH
`define SWS_DEFINES_VH
`define SWS_ADDR_CTRL     12'h000
`define SWS_ADDR_TIMING   12'h004
`define SWS_ADDR_STATUS   12'h008
`define SWS_ADDR_CAPTURE  12'h00c
`define SWS_EN_DISABLED   2'h0
`define SWS_EN_FILTER     2'h1
`define SWS_EN_NOFILTER   2'h2
`define SWS_CTRL_EN_LSB   0
`define SWS_CTRL_HSK      2
`define SWS_CTRL_MULTI    3
`define SWS_CTRL_DRIVE    4
`define SWS_CTRL_GSR      5
`define SWS_CTRL_MASK_LSB 8
`define SWS_CTRL_RESET    32'h0000ff00
`define SWS_OUT_CNT_RESET 8'h04
`define SWS_WR_CNT_RESET  8'h05
`define SWS_FILT_LEN      3'h4
// phase delays in 25 ns clock cycles: 100/200/300/400 ns entry, 100 ns enable, 100 ns awake
`define SWS_CYC_GWE       8'h04
`define SWS_CYC_AWAKE     8'h08
`define SWS_CYC_GTS       8'h0c
`define SWS_CYC_DIS       8'h10
`define SWS_CYC_EN        8'h04
`define SWS_CYC_AWK_HI    8'h04
`endif

// ===== bench/sws_sequencer_monitor.sv
// checker for entry and wake ordering at the sequencer ports
`timescale 1ns/1ps
module sws_sequencer_monitor (
  input logic CLK,
  input logic RESET_N,
  input logic AWAKE_IN,
  input logic AWAKE_OUT,
  input logic AWAKE_OE,
  input logic WRITE_ENABLE,
  input logic OUTPUT_HOLD,
  input logic INPUT_BLOCK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_hold_after_we: assert property ($rose(OUTPUT_HOLD) |-> !WRITE_ENABLE)
    else $error("outputs held while storage writable");
  a_awake_low_first: assert property ($rose(OUTPUT_HOLD) |-> AWAKE_OE && !AWAKE_OUT)
    else $error("wake status not low at output hold");
  a_block_follows: assert property ($rose(OUTPUT_HOLD) |-> ##[1:8] INPUT_BLOCK)
    else $error("inputs not blocked after output hold");
  a_block_last: assert property ($rose(INPUT_BLOCK) |-> OUTPUT_HOLD && !WRITE_ENABLE)
    else $error("inputs blocked out of order");
  a_unblock_locked: assert property ($fell(INPUT_BLOCK) |-> !WRITE_ENABLE && OUTPUT_HOLD)
    else $error("inputs released with storage unlocked");
  a_awake_drive: assert property ($fell(INPUT_BLOCK) |-> ##[0:8] (!AWAKE_OE || AWAKE_OUT))
    else $error("wake status neither driven high nor released");
  a_release_awake: assert property ($fell(OUTPUT_HOLD) |-> AWAKE_IN)
    else $error("outputs released before wake status high");
  a_we_after_out: assert property ($fell(OUTPUT_HOLD) |-> !WRITE_ENABLE ##1 WRITE_ENABLE)
    else $error("write release not one cycle after output release");
  a_we_last: assert property ($rose(WRITE_ENABLE) |-> !OUTPUT_HOLD && !INPUT_BLOCK)
    else $error("storage unlocked before outputs restored");
endmodule // sws_sequencer_monitor
bind sws_sequencer sws_sequencer_monitor mon_u (.CLK(CLK), .RESET_N(RESET_N),
  .AWAKE_IN(AWAKE_IN), .AWAKE_OUT(AWAKE_OUT), .AWAKE_OE(AWAKE_OE),
  .WRITE_ENABLE(WRITE_ENABLE), .OUTPUT_HOLD(OUTPUT_HOLD), .INPUT_BLOCK(INPUT_BLOCK));

// ===== bench/sws_partner.sv
// system controller and user logic around the sequencer
`timescale 1ns/1ps
module sws_partner (
  input  logic       clk,
  input  logic       rst_n,
  input  logic       sleep_cmd,
  input  logic [7:0] wake_cmd,
  input  logic       hold_awake_low,
  input  logic [7:0] ack_delay,
  input  logic       entry_request_out,
  input  logic       awake_out,
  input  logic       awake_oe,
  output logic       sleep_req,
  output logic [7:0] wake_pins,
  output logic       entry_acknowledge,
  output logic       awake_in
);
  logic [7:0] cnt_ff;
  assign sleep_req = sleep_cmd;
  assign wake_pins = wake_cmd;
  // the sequencer's drive wins; undriven, the pull-up wins unless the system holds the shared pin low
  assign awake_in = awake_oe ? awake_out : !hold_awake_low;
  // user logic needs ack_delay cycles to park its state before acknowledging
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n || !entry_request_out) cnt_ff <= 8'h00;
    else if (cnt_ff != 8'hff) cnt_ff <= cnt_ff + 8'h01;
  end
  assign entry_acknowledge = entry_request_out && (cnt_ff >= ack_delay);
endmodule // sws_partner

// ===== bench/sws_sequencer_tb.sv
// self-checking bench for the suspend/wake sequencer
`timescale 1ns/1ps
module sws_sequencer_tb;
  logic        CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, CONFIG_DONE = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, rd;
  logic [7:0]  HOLD_LAST_LEVEL = 8'ha5, wake_cmd = 0, ack_dly = 8'h1e;
  logic        sleep_cmd = 0, hold_lo = 0;
  wire  [31:0] PRDATA;
  wire  [7:0]  WAKE_PINS, HOLD_CAPTURED;
  wire         PREADY, PSLVERR, SLEEP_REQ, ENTRY_ACKNOWLEDGE, ENTRY_REQUEST_OUT, WRITE_ENABLE;
  wire         OUTPUT_HOLD, INPUT_BLOCK, GLOBAL_SET_RESET, AWAKE_IN, AWAKE_OUT, AWAKE_OE;
  wire         AWAKE_IS_STATUS;
  int          err_count = 0, compares = 0, gsr_cnt = 0, g0, n;
  sws_sequencer dut_u (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SLEEP_REQ(SLEEP_REQ), .WAKE_PINS(WAKE_PINS), .CONFIG_DONE(CONFIG_DONE),
    .ENTRY_ACKNOWLEDGE(ENTRY_ACKNOWLEDGE), .ENTRY_REQUEST_OUT(ENTRY_REQUEST_OUT),
    .HOLD_LAST_LEVEL(HOLD_LAST_LEVEL), .HOLD_CAPTURED(HOLD_CAPTURED),
    .WRITE_ENABLE(WRITE_ENABLE), .OUTPUT_HOLD(OUTPUT_HOLD), .INPUT_BLOCK(INPUT_BLOCK),
    .GLOBAL_SET_RESET(GLOBAL_SET_RESET), .AWAKE_IN(AWAKE_IN), .AWAKE_OUT(AWAKE_OUT),
    .AWAKE_OE(AWAKE_OE), .AWAKE_IS_STATUS(AWAKE_IS_STATUS));
  sws_partner prt_u (.clk(CLK), .rst_n(RESET_N), .sleep_cmd(sleep_cmd), .wake_cmd(wake_cmd),
    .hold_awake_low(hold_lo), .ack_delay(ack_dly), .entry_request_out(ENTRY_REQUEST_OUT),
    .awake_out(AWAKE_OUT), .awake_oe(AWAKE_OE), .sleep_req(SLEEP_REQ), .wake_pins(WAKE_PINS),
    .entry_acknowledge(ENTRY_ACKNOWLEDGE), .awake_in(AWAKE_IN));
  always #12.5 CLK = ~CLK;
  always @(negedge CLK) gsr_cnt += GLOBAL_SET_RESET;
  task stop_test;
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge CLK);
    PSEL <= 1; PENABLE <= 0; PWRITE <= wr; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  function logic sg(input int i);
    case (i)
      0: sg = WRITE_ENABLE;
      1: sg = OUTPUT_HOLD;
      2: sg = INPUT_BLOCK;
      default: sg = ENTRY_REQUEST_OUT;
    endcase
  endfunction
  // bounded wait on one sequencer output, sampled mid-cycle
  task wt(input int i, input logic v);
    n = 0;
    do begin @(negedge CLK); n++; end while (sg(i) !== v && n < 400);
    chk(sg(i), v);
  endtask
  task settle(input int c);
    repeat (c) @(negedge CLK);
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    RESET_N <= 1;
    @(posedge CLK) CONFIG_DONE <= 1;
    apb(0, 12'h000, 0, rd);
    chk(rd, 32'h0000ff00);
    apb(0, 12'h004, 0, rd);
    chk(rd, 32'h00000504);
    apb(1, 12'h010, 32'hffffffff, rd);
    apb(0, 12'h010, 0, rd);
    chk(rd, 0);
    chk({PREADY, PSLVERR}, 2'h2);
    sleep_cmd <= 1;
    settle(40);
    chk({WRITE_ENABLE, OUTPUT_HOLD, INPUT_BLOCK}, 3'h4);
    @(posedge CLK) sleep_cmd <= 0;
    for (int m = 0; m < 3; m++) begin
      apb(1, 12'h000, m, rd);
      settle(2);
      chk(AWAKE_IS_STATUS, m != 0);
    end
    apb(1, 12'h000, 32'h0000ff32, rd);
    @(posedge CLK) sleep_cmd <= 1;
    wt(0, 0);
    @(posedge CLK) HOLD_LAST_LEVEL <= 8'h5a;
    chk(HOLD_CAPTURED, 0);
    wt(1, 1);
    chk({HOLD_CAPTURED, AWAKE_OUT}, {8'ha5, 1'b0});
    wt(2, 1);
    @(posedge CLK) sleep_cmd <= 0;
    wt(2, 0);
    wt(1, 0);
    n = 0;
    while (WRITE_ENABLE !== 1'b1 && n < 20) begin @(negedge CLK); n++; end
    chk(n, 1);
    chk(gsr_cnt != 0, 1);
    g0 = gsr_cnt;
    apb(1, 12'h000, 32'h00000f0d, rd);
    @(posedge CLK) sleep_cmd <= 1;
    wt(3, 1);
    settle(20);
    chk(WRITE_ENABLE, 1);
    wt(2, 1);
    @(posedge CLK) begin sleep_cmd <= 0; hold_lo <= 1; end
    settle(30);
    chk(INPUT_BLOCK, 1);
    @(posedge CLK) wake_cmd <= 8'h80;
    settle(30);
    chk(INPUT_BLOCK, 1);
    @(posedge CLK) wake_cmd <= 8'h81;
    wt(2, 0);
    settle(30);
    chk({OUTPUT_HOLD, AWAKE_OE}, 2'h2);
    @(posedge CLK) hold_lo <= 0;
    wt(0, 1);
    chk(gsr_cnt, g0);
    apb(1, 12'h000, 32'h0000ff02, rd);
    @(posedge CLK) begin wake_cmd <= 0; sleep_cmd <= 1; end
    wt(1, 1);
    @(posedge CLK) RESET_N <= 0;
    settle(1);
    chk({WRITE_ENABLE, OUTPUT_HOLD, AWAKE_IS_STATUS}, 3'h4);
    @(posedge CLK) sleep_cmd <= 0;
    @(posedge CLK) RESET_N <= 1;
    settle(2);
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    stop_test;
  end
endmodule // sws_sequencer_tb
